// *** rtl/adcos_pkg.sv ***
package adcos_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int ADCOS_SAR_W = 10;
    localparam int ADCOS_BYTE_W = 8;
    localparam int ADCOS_CNT_W = 6;

    // ----------------------------------------
    // timing in converter clock cycles
    // ----------------------------------------
    localparam int ADCOS_CONV8_CYC = 49;
    localparam int ADCOS_CONV10_CYC = 59;
    localparam int ADCOS_CMP_CYC = 14;
    localparam int ADCOS_SAR_STEPS = 10;

    // ----------------------------------------
    // codes and reset values
    // ----------------------------------------
    localparam logic [1:0] ADCOS_THR_LSB = 2'h2;
    localparam logic [9:0] ADCOS_SAR_MSB = 10'h200;
    localparam logic [9:0] ADCOS_SAR_RST = 10'h000;
    localparam logic [9:0] ADCOS_RES_RST = 10'h000;

endpackage

// *** rtl/adcos_sequencer.sv ***
`timescale 1ns/1ps
module adcos_sequencer
    import adcos_pkg::*;
#(
    parameter int NCH = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic start_set_i,
    input wire logic start_clr_i,
    input wire logic repeat_mode_i,
    input wire logic res8_i,
    input wire logic [$clog2(NCH)-1:0] chan_sel_i,
    input wire logic [NCH-1:0] cmp_sel_i,
    input wire logic res_wr_i,
    input wire logic [$clog2(NCH)-1:0] res_wr_ch_i,
    input wire logic [ADCOS_BYTE_W-1:0] res_wr_data_i,
    input wire logic [$clog2(NCH)-1:0] res_rd_ch_i,
    input wire logic comp_i,
    output logic [ADCOS_SAR_W-1:0] dac_code_o,
    output logic [ADCOS_SAR_W-1:0] res_rd_data_o,
    output logic [NCH-1:0] cmp_res_o,
    output logic start_o,
    output logic irq_o
);

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    localparam logic [5:0] LAST8 = 6'(ADCOS_CONV8_CYC - 1);
    localparam logic [5:0] LAST10 = 6'(ADCOS_CONV10_CYC - 1);
    localparam logic [5:0] LASTC = 6'(ADCOS_CMP_CYC - 1);
    localparam logic [5:0] STEPS = 6'(ADCOS_SAR_STEPS);

    logic start_r;
    logic irq_r;
    logic [ADCOS_CNT_W-1:0] cnt_r;
    logic [ADCOS_SAR_W-1:0] sar_r;
    logic [ADCOS_SAR_W-1:0] bit_r;
    logic [ADCOS_SAR_W-1:0] res_r [NCH];
    logic [ADCOS_SAR_W-1:0] rd_r;
    logic [NCH-1:0] cmpres_r;
    logic cmp_now;
    logic [5:0] last;
    logic [5:0] load_at;
    logic done;
    logic step;
    logic [ADCOS_SAR_W-1:0] sar_fin;
    logic [ADCOS_SAR_W-1:0] thr;

    assign cmp_now = cmp_sel_i[chan_sel_i];
    assign last = cmp_now ? LASTC : (res8_i ? LAST8 : LAST10);
    assign load_at = last - STEPS;
    assign done = start_r && (cnt_r == last);
    // the sar steps fill the last ten cycles of the window
    assign step = start_r && !cmp_now && (cnt_r > load_at);
    // a set comparator bit keeps the trial bit; msb first
    assign sar_fin = comp_i ? sar_r : (sar_r & ~bit_r);
    assign thr = {res_r[chan_sel_i][ADCOS_BYTE_W-1:0], ADCOS_THR_LSB};

    // ----------------------------------------
    // start bit
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_r <= 1'b0;
        end else if (start_set_i) begin
            start_r <= 1'b1;
        end else if (start_clr_i) begin
            start_r <= 1'b0;
        end else if (done && !repeat_mode_i) begin
            start_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // cycle counter
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
        end else if (!start_r || start_clr_i || done) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 6'h01;
        end
    end

    // ----------------------------------------
    // successive approximation / threshold
    // ----------------------------------------
    // sar_r is also the code fed to the reference dac
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sar_r <= ADCOS_SAR_RST;
            bit_r <= ADCOS_SAR_RST;
        end else if (cmp_now && (start_set_i || start_r)) begin
            sar_r <= thr;
            bit_r <= ADCOS_SAR_RST;
        end else if (start_r && cnt_r == load_at) begin
            sar_r <= ADCOS_SAR_MSB;
            bit_r <= ADCOS_SAR_MSB;
        end else if (step) begin
            sar_r <= sar_fin | (bit_r >> 1);
            bit_r <= bit_r >> 1;
        end
    end

    assign dac_code_o = sar_r;

    // ----------------------------------------
    // result store
    // ----------------------------------------
    // hardware store wins over a software write to the same channel
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NCH; i++) begin
                res_r[i] <= ADCOS_RES_RST;
            end
        end else begin
            if (res_wr_i) begin
                res_r[res_wr_ch_i] <= {2'h0, res_wr_data_i};
            end
            if (done && !cmp_now && res8_i) begin
                res_r[chan_sel_i] <= {2'h0, sar_fin[9:2]};
            end else if (done && !cmp_now) begin
                res_r[chan_sel_i] <= sar_fin;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmpres_r <= '0;
        end else if (done && cmp_now) begin
            cmpres_r[chan_sel_i] <= comp_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_r <= ADCOS_RES_RST;
        end else begin
            rd_r <= res_r[res_rd_ch_i];
        end
    end

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= done && !repeat_mode_i;
        end
    end

    assign res_rd_data_o = rd_r;
    assign cmp_res_o = cmpres_r;
    assign start_o = start_r;
    assign irq_o = irq_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // mode inputs are assumed steady while the start bit is set
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    oneshot_irq_a: assert property (done && !repeat_mode_i |=> irq_o)
        else $error("no irq after one-shot completion");
    repeat_noirq_a: assert property (irq_o |-> $past(!repeat_mode_i))
        else $error("irq raised in repeat mode");
    self_clear_a: assert property (done && !repeat_mode_i && !start_set_i |=> !start_o)
        else $error("start bit not cleared after one-shot");
    repeat_hold_a: assert property (done && repeat_mode_i && !start_clr_i |=> start_o)
        else $error("start bit dropped in repeat mode");
    conv10_len_a: assert property ($rose(start_o) && !cmp_now && !res8_i |-> ##58 (done || !start_o))
        else $error("10-bit conversion not done at 59 cycles");
    conv8_len_a: assert property ($rose(start_o) && !cmp_now && res8_i |-> ##48 (done || !start_o))
        else $error("8-bit conversion not done at 49 cycles");
    cmp_len_a: assert property ($rose(start_o) && cmp_now |-> ##13 (done || !start_o))
        else $error("comparison not done at 14 cycles");
    result_store_a: assert property (done && !cmp_now && !res8_i && !res_wr_i
        |=> res_r[$past(chan_sel_i)] == $past(sar_fin))
        else $error("conversion result not stored");
    res8_upper_a: assert property (done && !cmp_now && res8_i |=> res_r[$past(chan_sel_i)][9:8] == 2'h0)
        else $error("8-bit result has upper bits set");
    cmp_store_a: assert property (done && cmp_now |=> cmp_res_o[$past(chan_sel_i)] == $past(comp_i))
        else $error("comparison outcome not stored");
    thr_code_a: assert property (start_r && cmp_now && !done |-> dac_code_o[1:0] == ADCOS_THR_LSB)
        else $error("threshold low bits wrong");
    stop_now_a: assert property (start_clr_i && !start_set_i |=> !start_o && cnt_r == 6'h00)
        else $error("start clear did not stop conversion");

    oneshot_c: cover property (done && !repeat_mode_i && !cmp_now ##1 irq_o);
    repeat_c: cover property (done && repeat_mode_i ##1 start_o [*8] ##[1:80] done);
    compare_c: cover property (done && cmp_now && comp_i);
    abort_c: cover property (start_o && cnt_r > 6'h05 && start_clr_i);
    repeat_cmp_c: cover property (done && cmp_now && repeat_mode_i ##14 done);

    // ----------------------------------------
    // run length bound
    // ----------------------------------------
    // counted apart from cnt_r so a stuck sequencing counter still shows up
    logic [6:0] run_len_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_len_r <= 7'h00;
        end else if (start_r && !done && !start_clr_i) begin
            run_len_r <= run_len_r + 7'h01;
        end else begin
            run_len_r <= 7'h00;
        end
    end

    run_bound_a: assert property (start_r |-> run_len_r <= 7'(ADCOS_CONV10_CYC - 1))
        else $error("run longer than a 10-bit conversion");

    // ----------------------------------------
    // rule checks
    // ----------------------------------------
    // request bit lives outside, so a wide pulse would count twice there
    irq_pulse_a: assert property (irq_o |=> !irq_o)
        else $error("irq longer than one cycle");

    irq_from_done_a: assert property (irq_o |-> $past(done))
        else $error("irq without a completion");

    rep_done_quiet_a: assert property (done && repeat_mode_i |=> !irq_o)
        else $error("irq after a repeat completion");

    start_take_a: assert property (start_set_i |=> start_o)
        else $error("start bit not set");

    idle_cnt_a: assert property (!start_o |-> cnt_r == 6'h00)
        else $error("counter running while halted");

    sar_load_a: assert property (start_r && !cmp_now && cnt_r == load_at |=> dac_code_o == ADCOS_SAR_MSB)
        else $error("sar not loaded with msb trial");

    load_msb_a: assert property (bit_r == ADCOS_SAR_MSB |-> dac_code_o[9])
        else $error("msb trial bit missing");

    msb_first_a: assert property (step |=> bit_r == ($past(bit_r) >> 1))
        else $error("trial bit not moving down");

    ten_steps_a: assert property (done && !cmp_now |-> bit_r == 10'h001)
        else $error("conversion done before tenth step");

    full_scale_a: assert property (done && !cmp_now && !res8_i && sar_fin == 10'h3ff
        |=> res_r[$past(chan_sel_i)] == 10'h3ff)
        else $error("full scale code not stored");

    res8_low_a: assert property (done && !cmp_now && res8_i |=> res_r[$past(chan_sel_i)][7:0] == $past(sar_fin[9:2]))
        else $error("8-bit result not upper sar bits");

    thr_byte_a: assert property (start_r && cmp_now && $past(start_r) && !$past(res_wr_i)
        |-> dac_code_o[9:2] == res_r[chan_sel_i][7:0])
        else $error("threshold byte differs from result");

    cmp_no_trial_a: assert property (start_r && cmp_now |-> bit_r == 10'h000)
        else $error("trial bit active during comparison");

    dac_idle_a: assert property (!start_r && !start_set_i |=> $stable(dac_code_o))
        else $error("dac code moved while halted");

    res_wr_a: assert property (res_wr_i && !(done && !cmp_now)
        |=> res_r[$past(res_wr_ch_i)] == {2'h0, $past(res_wr_data_i)})
        else $error("software result write lost");

    read_path_a: assert property (1'b1 |=> res_rd_data_o == $past(res_r[res_rd_ch_i]))
        else $error("read data not the addressed result");

    set_ignored_a: assert property (start_set_i && start_r && !done && !start_clr_i |=> cnt_r == $past(cnt_r) + 6'h01)
        else $error("start write restarted a running conversion");

    oneshot_halt_a: assert property (done && !repeat_mode_i && !start_set_i |=> cnt_r == 6'h00 && !step)
        else $error("converter not halted after one-shot");

    repeat_restart_a: assert property (done && repeat_mode_i && !start_clr_i |=> cnt_r == 6'h00 && start_o)
        else $error("repeat run not restarted");

    conv_keeps_cmp_a: assert property (done && !cmp_now |=> $stable(cmp_res_o))
        else $error("conversion touched comparison bits");

    cmp_rep_a: assert property (done && cmp_now && repeat_mode_i && !start_clr_i
        |=> start_o && dac_code_o[1:0] == ADCOS_THR_LSB)
        else $error("repeat comparison not continued");

    cmp_keeps_res_a: assert property (done && cmp_now && !res_wr_i
        |=> res_r[$past(chan_sel_i)] == $past(res_r[chan_sel_i]))
        else $error("comparison overwrote the result");

    res_only_done_a: assert property (!done && !res_wr_i
        |=> res_r[$past(chan_sel_i)] == $past(res_r[chan_sel_i]))
        else $error("result changed without a completion");

    irq_halts_a: assert property (irq_o |-> !start_o || $past(start_set_i))
        else $error("start bit still set at one-shot irq");

    cnt_window_a: assert property (start_r |-> cnt_r <= last)
        else $error("counter beyond its window");

    cmp_window_a: assert property (start_r && cmp_now |-> cnt_r <= LASTC)
        else $error("comparison counter beyond 14 cycles");

endmodule

// *** testbench/adcos_ain_model.sv ***
`timescale 1ns/1ps
module adcos_ain_model
    import adcos_pkg::*;
(
    input wire logic [ADCOS_SAR_W-1:0] dac_code_i,
    input wire logic [ADCOS_SAR_W:0] level_i,
    output logic comp_o
);
    // ----
    // analog input
    // ----
    // level in reference steps, above 10'h3ff means between reference and supply
    // equal level reads as not above, like a real comparator at its edge
    assign comp_o = level_i > {1'b0, dac_code_i};
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import adcos_pkg::*;
    logic clk_i = 1'b0, rst_b_i = 1'b0, st_set = 1'b0, st_clr = 1'b0, rpt = 1'b0, res8 = 1'b0, wr = 1'b0;
    logic [2:0] ch = 3'h0;
    logic [7:0] cmp_sel = 8'h00, wr_data = 8'h00, cmp_res, exp_cmp = 8'h00;
    logic [10:0] level = 11'h000;
    logic [9:0] dac, rd;
    logic start, irq, comp, chk_nxt = 1'b0, start_d = 1'b0;
    logic [25:0] exp_q[$];
    logic [25:0] e = 26'h0;
    int n_fail = 0, tests_run = 0, cyc = 0, tmo = 0;
    initial forever #10 clk_i = ~clk_i;
    adcos_sequencer u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_set_i(st_set), .start_clr_i(st_clr),
        .repeat_mode_i(rpt), .res8_i(res8), .chan_sel_i(ch), .cmp_sel_i(cmp_sel), .res_wr_i(wr),
        .res_wr_ch_i(ch), .res_wr_data_i(wr_data), .res_rd_ch_i(ch), .comp_i(comp), .dac_code_o(dac),
        .res_rd_data_o(rd), .cmp_res_o(cmp_res), .start_o(start), .irq_o(irq));
    adcos_ain_model u_ain (.dac_code_i(dac), .level_i(level), .comp_o(comp));
    // ----
    // helpers
    // ----
    task check(input logic [9:0] seen, input logic [9:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // strict compare keeps a bit only while input is above the trial code
    function automatic logic [9:0] conv(input logic [10:0] v);
        conv = (v == 11'h000) ? 10'h000 : (v > 11'h400) ? 10'h3ff : v[9:0] - 10'h001;
    endfunction
    task go_wait;
        @(posedge clk_i) st_set <= 1'b1;
        @(posedge clk_i) st_set <= 1'b0;
        for (int k = 0; k < 80 && irq !== 1'b1; k++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
    endtask
    task run(input logic is8, input logic [10:0] v);
        logic [9:0] r;
        r = conv(v);
        exp_q.push_back({is8 ? 8'h31 : 8'h3b, exp_cmp, is8 ? {2'b00, r[9:2]} : r});
        level <= v;
        res8 <= is8;
        cmp_sel <= 8'h00;
        go_wait;
    endtask
    task cmp_run(input logic [2:0] c, input logic [7:0] b, input logic [10:0] v);
        exp_cmp[c] = v > {1'b0, b, 2'b10};
        exp_q.push_back({8'h0e, exp_cmp, 2'b00, b});
        @(posedge clk_i) wr <= 1'b1;
        wr_data <= b;
        level <= v;
        cmp_sel <= 8'h01 << c;
        @(posedge clk_i) wr <= 1'b0;
        go_wait;
    endtask
    // ----
    // result monitor
    // ----
    always @(posedge clk_i) begin
        start_d <= start;
        cyc <= (start && !start_d) ? 1 : cyc + 1;
        tmo <= tmo + 1;
        if (chk_nxt) begin
            check(rd, e[9:0], "result");
            check({2'b00, cmp_res}, {2'b00, e[17:10]}, "cmp bits");
        end
        chk_nxt <= 1'b0;
        if (irq === 1'b1) begin
            if (exp_q.size() == 0) check(10'h001, 10'h000, "irq");
            else begin
                e = exp_q.pop_front();
                check(cyc[9:0], {2'b00, e[25:18]}, "cycles");
                check({9'h000, start}, 10'h000, "start");
                chk_nxt <= 1'b1;
            end
        end
        if (tmo == 20000) begin
            n_fail++;
            test_done;
        end
    end
    // ----
    // stimulus
    // ----
    initial begin
        logic [7:0] rb;
        logic [2:0] rc;
        void'($urandom(32'hbec8));
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            ch <= 3'($urandom % 8);
            run(i[0], 11'($urandom % 1100));
        end
        run(1'b0, 11'h7ff);
        for (int i = 0; i < 6; i++) begin
            rc = 3'($urandom % 8);
            rb = 8'($urandom);
            ch <= rc;
            cmp_run(rc, rb, {1'b0, rb, 2'b10} + 11'(i % 3) - 11'h001);
        end
        @(posedge clk_i) rpt <= 1'b1;
        cmp_sel <= 8'h00;
        res8 <= 1'b0;
        level <= 11'h155;
        st_set <= 1'b1;
        @(posedge clk_i) st_set <= 1'b0;
        repeat (62) @(posedge clk_i);
        check(rd, conv(11'h155), "repeat result");
        level <= 11'h2aa;
        repeat (60) @(posedge clk_i);
        check(rd, conv(11'h2aa), "repeat result");
        check({9'h000, start}, 10'h001, "start held");
        repeat (10) @(posedge clk_i);
        st_clr <= 1'b1;
        @(posedge clk_i) st_clr <= 1'b0;
        repeat (70) @(posedge clk_i);
        check(rd, conv(11'h2aa), "kept result");
        check({9'h000, start}, 10'h000, "stopped");
        // kept result 2a9 gives threshold 2a6
        @(posedge clk_i) cmp_sel <= 8'h01 << ch;
        level <= 11'h2a7;
        st_set <= 1'b1;
        @(posedge clk_i) st_set <= 1'b0;
        repeat (15) @(posedge clk_i);
        check({9'h000, cmp_res[ch]}, 10'h001, "repeat cmp");
        level <= 11'h2a5;
        repeat (14) @(posedge clk_i);
        check({9'h000, cmp_res[ch]}, 10'h000, "repeat cmp");
        st_clr <= 1'b1;
        @(posedge clk_i) st_clr <= 1'b0;
        test_done;
    end
endmodule
